/* File: core/abtp_map.vh */
`ifndef ABTP_MAP_VH
`define ABTP_MAP_VH
// byte codes
`define ABTP_CH_HASH 8'h23
`define ABTP_CH_ZERO 8'h30
`define ABTP_CH_NINE 8'h39
`define ABTP_CH_SP 8'h20
`define ABTP_CH_TAB 8'h09
`define ABTP_CH_LF 8'h0a
`define ABTP_CH_CR 8'h0d
// error codes
`define ABTP_ERR_NONE 3'h0
`define ABTP_ERR_ODD 3'h1
`define ABTP_ERR_DIGIT 3'h2
`define ABTP_ERR_SHORT 3'h3
`define ABTP_ERR_MARK 3'h4
`define ABTP_ERR_LONG 3'h5
// count field width
`define ABTP_CNT_W 32
`endif

/* File: core/abtp_parser.v */
// Operation
// - accept definite blocks with a byte count and indefinite blocks ended by terminator
// - payload bytes pair into samples, high byte first
// - samples are signed, -8191 to 8191, zero is two zero bytes
// - definite preamble starts with one digit giving count digit number
// - count digits are decimal ASCII, most significant first, giving payload bytes
// - indefinite preamble is a lone zero, payload follows at once
// - binary replies are sent as indefinite blocks
// - order is header, whitespace, preamble, payload, terminator
// - malformed transfers push an error entry, except an odd serial indefinite block, bytes past a definite count or an end flag before the payload
`include "abtp_map.vh"
`timescale 1ns/1ns
`default_nettype none
module abtp_parser (
    input wire clk_sys_i,
    input wire nrst_i,
    // receive byte stream, after command header match
    input wire rx_start_i,
    input wire rx_valid_i,
    input wire [7:0] rx_byte_i,
    input wire rx_eoi_i,
    input wire rx_serial_i,
    output reg rx_ready_o,
    // sample output
    output reg smp_valid_o,
    output reg [15:0] smp_data_o,
    input wire smp_ready_i,
    output reg blk_done_o,
    // error queue push
    output reg err_push_o,
    output reg [2:0] err_code_o,
    // transmit formatter
    input wire tx_start_i,
    input wire tx_smp_valid_i,
    input wire [15:0] tx_smp_i,
    input wire tx_last_i,
    input wire tx_serial_i,
    output reg tx_smp_ready_o,
    output reg tx_valid_o,
    output reg [7:0] tx_byte_o,
    output reg tx_eoi_o,
    input wire tx_ready_i
);
    // ************************************
    // reset release
    // ************************************
    reg rst_m_q;
    reg rst_n_q;
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    function is_digit;
        input [7:0] b;
        begin
            is_digit = (b >= `ABTP_CH_ZERO) && (b <= `ABTP_CH_NINE);
        end
    endfunction

    function is_ws;
        input [7:0] b;
        begin
            is_ws = (b == `ABTP_CH_SP) || (b == `ABTP_CH_TAB);
        end
    endfunction

    // ************************************
    // receive parser
    // ************************************
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_WS = 3'h1;
    localparam [2:0] S_NDIG = 3'h2;
    localparam [2:0] S_CNT = 3'h3;
    localparam [2:0] S_DEF = 3'h4;
    localparam [2:0] S_INDEF = 3'h5;
    localparam [2:0] S_TERM = 3'h6;
    localparam [2:0] S_SKIP = 3'h7;

    reg [2:0] st_q;
    reg [3:0] ndig_q;
    reg [`ABTP_CNT_W-1:0] cnt_q;
    reg [7:0] hi_q;
    reg half_q;
    // two-entry sample buffer
    reg [15:0] buf_q [0:1];
    reg wp_q;
    reg rp_q;
    reg [1:0] fill_q;
    reg pend_q;
    reg [15:0] pend_d_q;

    wire term_b = rx_serial_i ? (rx_byte_i == `ABTP_CH_LF || rx_byte_i == `ABTP_CH_CR) : 1'b0;
    wire take = rx_valid_i && rx_ready_o;
    wire buf_push = pend_q && (fill_q != 2'd2);
    wire buf_pop = smp_valid_o && smp_ready_i;

    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= S_IDLE;
            ndig_q <= 4'h0;
            cnt_q <= {`ABTP_CNT_W{1'b0}};
            hi_q <= 8'h00;
            half_q <= 1'b0;
            pend_q <= 1'b0;
            pend_d_q <= 16'h0000;
            err_push_o <= 1'b0;
            err_code_o <= `ABTP_ERR_NONE;
            blk_done_o <= 1'b0;
            rx_ready_o <= 1'b0;
        end else begin
            err_push_o <= 1'b0;
            blk_done_o <= 1'b0;
            if (buf_push)
                pend_q <= 1'b0;
            // stall input while a sample waits for buffer room
            rx_ready_o <= (st_q != S_IDLE) && !(pend_q && !buf_push);
            if (rx_start_i) begin
                st_q <= S_WS;
                half_q <= 1'b0;
            end else if (take) begin
                case (st_q)
                    S_WS: begin
                        if (is_ws(rx_byte_i))
                            st_q <= S_WS;
                        else if (rx_byte_i == `ABTP_CH_HASH)
                            st_q <= S_NDIG;
                        else begin
                            err_push_o <= 1'b1;
                            err_code_o <= `ABTP_ERR_MARK;
                            st_q <= S_SKIP;
                        end
                    end
                    S_NDIG: begin
                        cnt_q <= {`ABTP_CNT_W{1'b0}};
                        if (rx_byte_i == `ABTP_CH_ZERO)
                            st_q <= S_INDEF;
                        else if (is_digit(rx_byte_i)) begin
                            ndig_q <= rx_byte_i[3:0];
                            st_q <= S_CNT;
                        end else begin
                            err_push_o <= 1'b1;
                            err_code_o <= `ABTP_ERR_DIGIT;
                            st_q <= S_SKIP;
                        end
                    end
                    S_CNT: begin
                        if (is_digit(rx_byte_i)) begin
                            // decimal accumulate, msd first
                            cnt_q <= (cnt_q << 3) + (cnt_q << 1) + {28'h0, rx_byte_i[3:0]};
                            ndig_q <= ndig_q - 4'h1;
                            if (ndig_q == 4'h1)
                                st_q <= S_DEF;
                        end else begin
                            err_push_o <= 1'b1;
                            err_code_o <= `ABTP_ERR_DIGIT;
                            st_q <= S_SKIP;
                        end
                    end
                    S_DEF: begin
                        if (cnt_q == {`ABTP_CNT_W{1'b0}}) begin
                            // empty payload, byte after a zero count ends the block
                            blk_done_o <= 1'b1;
                            st_q <= S_IDLE;
                        end else if (cnt_q[0] && !half_q && cnt_q != 1) begin
                            err_push_o <= 1'b1;
                            err_code_o <= `ABTP_ERR_ODD;
                            st_q <= S_SKIP;
                        end else if (rx_eoi_i && cnt_q != 1) begin
                            err_push_o <= 1'b1;
                            err_code_o <= `ABTP_ERR_SHORT;
                            st_q <= S_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 1;
                            half_q <= ~half_q;
                            if (!half_q)
                                hi_q <= rx_byte_i;
                            else begin
                                pend_q <= 1'b1;
                                pend_d_q <= {hi_q, rx_byte_i};
                            end
                            if (cnt_q == 1) begin
                                if (!half_q) begin
                                    err_push_o <= 1'b1;
                                    err_code_o <= `ABTP_ERR_ODD;
                                end
                                blk_done_o <= half_q;
                                st_q <= S_TERM;
                            end
                        end
                    end
                    S_INDEF: begin
                        if (term_b || (rx_eoi_i && rx_byte_i == `ABTP_CH_LF && half_q == 1'b0)) begin
                            blk_done_o <= 1'b1;
                            st_q <= S_IDLE;
                        end else if (rx_eoi_i) begin
                            err_push_o <= 1'b1;
                            err_code_o <= `ABTP_ERR_ODD;
                            st_q <= S_IDLE;
                        end else begin
                            half_q <= ~half_q;
                            if (!half_q)
                                hi_q <= rx_byte_i;
                            else begin
                                pend_q <= 1'b1;
                                pend_d_q <= {hi_q, rx_byte_i};
                            end
                        end
                    end
                    S_TERM: begin
                        if (rx_eoi_i || term_b)
                            st_q <= S_IDLE;
                    end
                    S_SKIP: begin
                        if (rx_eoi_i || term_b)
                            st_q <= S_IDLE;
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end

    // buffer storage, pointer and fill count
    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            buf_q[0] <= 16'h0000;
            buf_q[1] <= 16'h0000;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            fill_q <= 2'd0;
            smp_valid_o <= 1'b0;
            smp_data_o <= 16'h0000;
        end else begin
            if (buf_push) begin
                buf_q[wp_q] <= pend_d_q;
                wp_q <= ~wp_q;
            end
            if (buf_pop)
                rp_q <= ~rp_q;
            fill_q <= fill_q + {1'b0, buf_push} - {1'b0, buf_pop};
            // present head entry registered
            if (!smp_valid_o || buf_pop) begin
                if (fill_q - {1'b0, buf_pop} != 2'd0) begin
                    smp_valid_o <= 1'b1;
                    smp_data_o <= buf_q[rp_q ^ buf_pop];
                end else
                    smp_valid_o <= 1'b0;
            end
        end
    end

    // ************************************
    // transmit formatter
    // ************************************
    localparam [1:0] T_IDLE = 2'h0;
    localparam [1:0] T_HASH = 2'h1;
    localparam [1:0] T_ZERO = 2'h2;
    localparam [1:0] T_DATA = 2'h3;

    reg [1:0] tst_q;
    reg [7:0] lo_q;
    reg tlast_q;
    reg [1:0] tph_q;
    wire tx_free = !tx_valid_o || tx_ready_i;

    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tst_q <= T_IDLE;
            tx_valid_o <= 1'b0;
            tx_byte_o <= 8'h00;
            tx_eoi_o <= 1'b0;
            tx_smp_ready_o <= 1'b0;
            lo_q <= 8'h00;
            tlast_q <= 1'b0;
            tph_q <= 2'd0;
        end else begin
            tx_smp_ready_o <= 1'b0;
            if (tx_free) begin
                tx_valid_o <= 1'b0;
                tx_eoi_o <= 1'b0;
                case (tst_q)
                    T_IDLE: begin
                        if (tx_start_i)
                            tst_q <= T_HASH;
                    end
                    T_HASH: begin
                        tx_valid_o <= 1'b1;
                        tx_byte_o <= `ABTP_CH_HASH;
                        tst_q <= T_ZERO;
                    end
                    T_ZERO: begin
                        tx_valid_o <= 1'b1;
                        tx_byte_o <= `ABTP_CH_ZERO;
                        tst_q <= T_DATA;
                        tph_q <= 2'd0;
                    end
                    T_DATA: begin
                        if (tph_q == 2'd0 && tx_smp_valid_i && !tx_smp_ready_o) begin
                            tx_valid_o <= 1'b1;
                            tx_byte_o <= tx_smp_i[15:8];
                            lo_q <= tx_smp_i[7:0];
                            tlast_q <= tx_last_i;
                            tx_smp_ready_o <= 1'b1;
                            tph_q <= 2'd1;
                        end else if (tph_q == 2'd1) begin
                            tx_valid_o <= 1'b1;
                            tx_byte_o <= lo_q;
                            tph_q <= tlast_q ? 2'd2 : 2'd0;
                        end else if (tph_q == 2'd2) begin
                            // LF terminator, eoi on parallel bus
                            tx_valid_o <= 1'b1;
                            tx_byte_o <= `ABTP_CH_LF;
                            tx_eoi_o <= !tx_serial_i;
                            tst_q <= T_IDLE;
                            tph_q <= 2'd0;
                        end
                    end
                    default: tst_q <= T_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/abtp_parser_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
`include "abtp_map.vh"
// ****************************************
// port checker for the block parser
// ****************************************
module abtp_parser_chk (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic rx_start_i,
    input wire logic rx_ready_o,
    input wire logic smp_valid_o,
    input wire logic [15:0] smp_data_o,
    input wire logic smp_ready_i,
    input wire logic blk_done_o,
    input wire logic err_push_o,
    input wire logic [2:0] err_code_o,
    input wire logic tx_serial_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic tx_eoi_o,
    input wire logic tx_ready_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // quiet outputs for two edges after reset
    property p_rst_quiet;
        $rose(nrst_i) |-> (!rx_ready_o && !smp_valid_o && !tx_valid_o)[*2];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
    property p_rdy_start;
        rx_start_i && !smp_valid_o |=> ##1 rx_ready_o;
    endproperty
    a_rdy_start: assert property (p_rdy_start) else $error("ready late after start");
    property p_smp_hold;
        smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_data_o);
    endproperty
    a_smp_hold: assert property (p_smp_hold) else $error("sample dropped while stalled");
    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_byte_o, tx_eoi_o});
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped while stalled");
    property p_eoi_lf;
        tx_valid_o && tx_eoi_o |-> tx_byte_o == `ABTP_CH_LF && !tx_serial_i;
    endproperty
    a_eoi_lf: assert property (p_eoi_lf) else $error("end flag on wrong byte");
    property p_err_pulse;
        err_push_o |=> !err_push_o;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error push not a pulse");
    property p_err_code;
        err_push_o |-> err_code_o != `ABTP_ERR_NONE;
    endproperty
    a_err_code: assert property (p_err_code) else $error("error push without code");
    property p_done_pulse;
        blk_done_o |=> !blk_done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
endmodule
bind abtp_parser abtp_parser_chk u_chk (.*);
`default_nettype wire

/* File: verification/abtp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// far side: byte sender and reply sink
// ****************************************
module abtp_host_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o,
    output logic rx_eoi_o,
    output logic tx_ready_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
        rx_eoi_o = 1'b0;
        tx_ready_o = 1'b0;
    end
    // hold one byte until the parser takes it
    task automatic send(input logic [7:0] b, input logic e);
        int n;
        @(negedge clk_i);
        rx_valid_o = 1'b1;
        rx_byte_o = b;
        rx_eoi_o = e;
        n = 0;
        while (!rx_ready_i && n < 500) begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
    endtask
    // release the line, leave no stale byte behind
    task automatic idle();
        @(negedge clk_i);
        rx_valid_o = 1'b0;
        rx_eoi_o = 1'b0;
        rx_byte_o = ~rx_byte_o;
    endtask
    // reply sink, stalls at random when asked
    always @(negedge clk_i) begin
        tx_ready_o <= stall_i ? 1'($urandom % 2) : 1'b1;
    end
endmodule
`default_nettype wire

/* File: verification/test_arb_block_transfer_parser.sv */
`timescale 1ns/1ns
`default_nettype none
`include "abtp_map.vh"
module test_arb_block_transfer_parser;
    logic clk_sys_i = 0, nrst_i = 0, rx_start_i = 0, rx_serial_i = 0, smp_ready_i = 0, stall = 0;
    logic tx_start_i = 0, tx_smp_valid_i = 0, tx_last_i = 0, tx_serial_i = 0;
    logic [15:0] tx_smp_i = 16'h0000;
    wire logic rx_valid_i, rx_eoi_i, rx_ready_o, smp_valid_o, blk_done_o, err_push_o;
    wire logic tx_smp_ready_o, tx_valid_o, tx_eoi_o, tx_ready_i;
    wire logic [7:0] rx_byte_i, tx_byte_o;
    wire logic [15:0] smp_data_o;
    wire logic [2:0] err_code_o;
    int bad_count = 0, cmp_count = 0, done_exp = 0, done_got = 0;
    logic [15:0] exp_smp[$];
    logic [2:0] exp_err[$];
    logic [8:0] exp_tx[$];
    always #4 clk_sys_i = ~clk_sys_i;
    abtp_parser uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rx_start_i(rx_start_i),
        .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .rx_eoi_i(rx_eoi_i), .rx_serial_i(rx_serial_i),
        .rx_ready_o(rx_ready_o), .smp_valid_o(smp_valid_o), .smp_data_o(smp_data_o),
        .smp_ready_i(smp_ready_i), .blk_done_o(blk_done_o), .err_push_o(err_push_o),
        .err_code_o(err_code_o), .tx_start_i(tx_start_i), .tx_smp_valid_i(tx_smp_valid_i),
        .tx_smp_i(tx_smp_i), .tx_last_i(tx_last_i), .tx_serial_i(tx_serial_i),
        .tx_smp_ready_o(tx_smp_ready_o), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
        .tx_eoi_o(tx_eoi_o), .tx_ready_i(tx_ready_i));
    abtp_host_model host (.clk_i(clk_sys_i), .stall_i(stall), .rx_ready_i(rx_ready_o),
        .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i), .rx_eoi_o(rx_eoi_i), .tx_ready_o(tx_ready_i));
    task automatic miss(input string m);
        $display("BAD %0t %s", $time, m);
        bad_count++;
    endtask
    task finish_test;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // sample sink with random stalls
    always @(negedge clk_sys_i) smp_ready_i <= stall ? 1'($urandom % 2) : 1'b1;
    // compare every result against the queued expectations
    always @(posedge clk_sys_i) begin
        if (blk_done_o) done_got++;
        if (smp_valid_o && smp_ready_i) begin
            cmp_count++;
            if (exp_smp.size() == 0 || smp_data_o !== exp_smp[0]) miss("sample");
            if (exp_smp.size() != 0) void'(exp_smp.pop_front());
        end
        if (err_push_o) begin
            cmp_count++;
            if (exp_err.size() == 0 || err_code_o !== exp_err[0]) miss("error code");
            if (exp_err.size() != 0) void'(exp_err.pop_front());
        end
        if (tx_valid_o && tx_ready_i) begin
            cmp_count++;
            if (exp_tx.size() == 0 || {tx_eoi_o, tx_byte_o} !== exp_tx[0]) miss("reply byte");
            if (exp_tx.size() != 0) void'(exp_tx.pop_front());
        end
    end
    // arm the parser once the sample path is empty
    task automatic arm(input logic ser);
        int n;
        n = 0;
        while (exp_smp.size() != 0 && n < 2000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 2000) miss("sample path stuck");
        @(negedge clk_sys_i);
        rx_serial_i = ser;
        rx_start_i = 1'b1;
        @(negedge clk_sys_i);
        rx_start_i = 1'b0;
        host.send(ser ? `ABTP_CH_TAB : `ABTP_CH_SP, 1'b0);
    endtask
    // random samples in range, high byte first; odd count leaves a lone byte
    task automatic data(input int cnt, input logic ser);
        logic [15:0] s;
        for (int i = 0; i < cnt; i += 2) begin
            s = 16'($urandom_range(16382) - 8191);
            if (ser) s = s & 16'h11f1;
            host.send(s[15:8], 1'b0);
            if (i + 1 < cnt) begin
                host.send(s[7:0], 1'b0);
                exp_smp.push_back(s);
            end
        end
    endtask
    task automatic defi(input int cnt);
        arm(1'b0);
        host.send(`ABTP_CH_HASH, 1'b0);
        if (cnt < 10) begin
            host.send(8'h31, 1'b0);
        end else begin
            host.send(8'h32, 1'b0);
            host.send(8'(8'h30 + cnt / 10), 1'b0);
        end
        host.send(8'(8'h30 + cnt % 10), 1'b0);
        data(cnt, 1'b0);
        done_exp++;
        host.idle();
    endtask
    task automatic indef(input int cnt, input logic ser);
        arm(ser);
        host.send(`ABTP_CH_HASH, 1'b0);
        host.send(`ABTP_CH_ZERO, 1'b0);
        data(cnt, ser);
        if (cnt % 2) exp_err.push_back(`ABTP_ERR_ODD);
        else done_exp++;
        host.send(ser ? `ABTP_CH_CR : `ABTP_CH_LF, !ser);
        host.idle();
    endtask
    // reply block: marker, lone zero, samples, line feed
    task automatic txblk(input logic ser, input int n);
        logic [15:0] s;
        int k;
        @(negedge clk_sys_i);
        tx_serial_i = ser;
        tx_start_i = 1'b1;
        exp_tx.push_back({1'b0, `ABTP_CH_HASH});
        exp_tx.push_back({1'b0, `ABTP_CH_ZERO});
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys_i);
            tx_start_i = 1'b0;
            s = 16'($urandom_range(16382) - 8191);
            exp_tx.push_back({1'b0, s[15:8]});
            exp_tx.push_back({1'b0, s[7:0]});
            tx_smp_valid_i = 1'b1;
            tx_smp_i = s;
            tx_last_i = (i == n - 1);
            k = 0;
            while (!tx_smp_ready_o && k < 500) begin
                @(negedge clk_sys_i);
                k++;
            end
            if (k == 500) miss("reply sample not taken");
            @(posedge clk_sys_i);
        end
        exp_tx.push_back({!ser, `ABTP_CH_LF});
        @(negedge clk_sys_i);
        tx_smp_valid_i = 1'b0;
        tx_last_i = 1'b0;
        repeat (200) @(negedge clk_sys_i);
    endtask
    initial begin
        #400000;
        miss("timeout");
        finish_test;
    end
    initial begin
        void'($urandom(65487));
        repeat (16) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        defi(6);
        stall = 1'b1;
        defi(10);
        indef(8, 1'b0);
        indef(6, 1'b1);
        indef(3, 1'b0);
        arm(1'b0);
        exp_err.push_back(`ABTP_ERR_MARK);
        host.send(8'h78, 1'b0);
        host.idle();
        arm(1'b0);
        exp_err.push_back(`ABTP_ERR_DIGIT);
        host.send(`ABTP_CH_HASH, 1'b0);
        host.send(8'h31, 1'b0);
        host.send(8'h3a, 1'b0);
        host.idle();
        arm(1'b0);
        host.send(`ABTP_CH_HASH, 1'b0);
        host.send(8'h31, 1'b0);
        host.send(8'h34, 1'b0);
        data(2, 1'b0);
        exp_err.push_back(`ABTP_ERR_SHORT);
        host.send(8'h12, 1'b1);
        host.idle();
        txblk(1'b0, 3);
        txblk(1'b1, 2);
        defi(2);
        repeat (300) @(negedge clk_sys_i);
        cmp_count++;
        if (done_got != done_exp || exp_smp.size() || exp_err.size() || exp_tx.size()) miss("leftover");
        finish_test;
    end
endmodule
`default_nettype wire
